//--- rtl/sacs_sequencer.sv
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// R1: selections act only while converter on
// R2: 10-bit result, right or left aligned
// R3: low byte read blocks result updates
// R4: high byte read releases the block
// R5: done flag sets even when blocked
// R6: start bit high until conversion ends
// R7: channel change waits for conversion end
// R8: auto trigger edge resets prescaler, starts
// R9: held level or busy edges ignored
// R10: source flag must clear before retrigger
// R11: done-flag source converts back to back
// R12: start works in auto mode, reads busy
// R13: prescaler runs only while converter on
// R14: start begins at next adc clock edge
// R15: 13 cycles normal, 25 first
// R16: hold at 1.5 normal, 13.5 first
// R17: completion writes result, sets done flag
// R18: auto hold two cycles, three sync cycles
// R19: free running restarts immediately
// R20: selection latched at conversion start
// R21: selection copying resumes in last cycle
// R22: external front end, strobes and decisions
module sacs_sequencer
  import sacs_pkg::*;
(
  input wire logic pclk, // cpu clock, 100 mhz
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic [7:0] trig_sources, // trigger source levels
  input wire logic cmp_decision, // comparator: input at or above dac
  output sacs_front_type front // strobes to the analog front end
);
  // bus decode
  logic acc;
  logic wr;
  logic rd;
  logic hit;
  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign rd = acc & ~pwrite;
  assign hit = (paddr == SACS_OFF_CTRL_A) | (paddr == SACS_OFF_CTRL_B) |
               (paddr == SACS_OFF_INSEL) | (paddr == SACS_OFF_RES_LO) |
               (paddr == SACS_OFF_RES_HI);
  assign pready = 1'b1;
  assign pslverr = acc & ~hit;
  // software registers
  logic on_ff;
  logic auto_ff;
  logic [2:0] div_ff;
  logic [2:0] tsel_ff;
  logic [7:0] insel_ff;
  logic done_ff;
  logic start_ff;
  logic block_ff;
  logic [9:0] result_ff;
  logic left_ff;
  logic first_ff;
  sacs_state_type state_ff;
  sacs_state_type nxt_state;
  logic [4:0] cyc_ff;
  logic [4:0] len_ff;
  logic [4:0] sh_ff;
  logic [9:0] sar_ff;
  logic [3:0] bit_ff;
  logic adc_tick;
  logic finish;
  logic trig_start;
  logic sw_start;
  assign sw_start = wr & (paddr == SACS_OFF_CTRL_A) & pwdata[SACS_CA_START] &
                    pwdata[SACS_CA_ON];
  // control register a and b fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_ff <= 1'b0;
      auto_ff <= 1'b0;
      div_ff <= 3'h0;
      tsel_ff <= 3'h0;
    end else if (wr && paddr == SACS_OFF_CTRL_A) begin
      on_ff <= pwdata[SACS_CA_ON];
      auto_ff <= pwdata[SACS_CA_AUTO];
      div_ff <= pwdata[SACS_CA_DIV +: 3];
    end else if (wr && paddr == SACS_OFF_CTRL_B) begin
      tsel_ff <= pwdata[2:0];
    end
  end
  // buffered selection, random access by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      insel_ff <= SACS_RST_BYTE;
    end else if (wr && paddr == SACS_OFF_INSEL) begin
      insel_ff <= pwdata[7:0];
    end
  end
  // working selection: copies buffer while on, unless locked in a conversion
  logic [4:0] chan_ff;
  logic [1:0] ref_ff;
  logic locked;
  assign locked = (state_ff == SACS_CONV) && (cyc_ff < len_ff - 5'h01); // see R21
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_ff <= 5'h00;
      ref_ff <= 2'h0;
    end else if (on_ff && !locked) begin // see R1, R7, R20
      chan_ff <= insel_ff[SACS_IS_CHAN +: 5];
      ref_ff <= insel_ff[SACS_IS_REF +: 2];
    end
  end
  // prescaler, held in reset while off or on trigger
  logic [7:0] pre_ff;
  logic [7:0] pre_max;
  assign pre_max = 8'((9'h002 << div_ff) - 9'h001);
  assign adc_tick = on_ff && (pre_ff == pre_max);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_ff <= 8'h00;
    end else if (!on_ff || trig_start || adc_tick) begin // see R13, R8
      pre_ff <= 8'h00;
    end else begin
      pre_ff <= pre_ff + 8'h01;
    end
  end
  // trigger synchronisation and edge detect
  logic [SACS_TRIG_SYNC-1:0] tsync_ff;
  logic trig_lvl;
  logic trig_edge;
  assign trig_lvl = (tsel_ff == SACS_TRIG_SRC_DONE[2:0]) ? done_ff : trig_sources[tsel_ff];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tsync_ff <= '0;
    end else begin
      tsync_ff <= {tsync_ff[SACS_TRIG_SYNC-2:0], trig_lvl}; // see R18
    end
  end
  assign trig_edge = tsync_ff[SACS_TRIG_SYNC-2] & ~tsync_ff[SACS_TRIG_SYNC-1];
  // edges while busy are dropped; done source restarts on finish
  assign trig_start = on_ff && auto_ff && (state_ff == SACS_IDLE) &&
                      (tsel_ff != SACS_TRIG_SRC_DONE[2:0]) && trig_edge; // see R9, R10
  logic free_run;
  assign free_run = auto_ff && (tsel_ff == SACS_TRIG_SRC_DONE[2:0]); // see R11, R19
  // conversion state machine
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      SACS_IDLE: begin
        if (trig_start) begin
          nxt_state = SACS_CONV;
        end else if (sw_start) begin
          nxt_state = SACS_WAIT; // see R12
        end
      end
      SACS_WAIT: begin
        if (!on_ff) begin
          nxt_state = SACS_IDLE;
        end else if (adc_tick) begin
          nxt_state = SACS_CONV; // see R14
        end
      end
      SACS_CONV: begin
        if (!on_ff) begin
          nxt_state = SACS_IDLE;
        end else if (finish && !free_run) begin
          nxt_state = SACS_IDLE;
        end
      end
      default: nxt_state = SACS_IDLE;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= SACS_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end
  assign finish = (state_ff == SACS_CONV) && adc_tick && (cyc_ff == len_ff - 5'h01);
  // a free-running restart follows a finished first conversion, so it is normal
  logic first_now;
  assign first_now = first_ff && !finish;
  // cycle counter and per-conversion length and hold point
  logic conv_begin;
  assign conv_begin = trig_start || (state_ff == SACS_WAIT && adc_tick && on_ff);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_ff <= 5'h00;
      len_ff <= SACS_LEN_NORMAL;
      sh_ff <= SACS_SH_NORMAL;
    end else if (conv_begin || (finish && free_run)) begin
      cyc_ff <= 5'h00;
      len_ff <= first_now ? SACS_LEN_FIRST : SACS_LEN_NORMAL; // see R15
      sh_ff <= first_now ? SACS_SH_FIRST : (trig_start ? SACS_SH_AUTO : SACS_SH_NORMAL); // see R16, R18
    end else if (state_ff == SACS_CONV && adc_tick) begin
      cyc_ff <= cyc_ff + 5'h01;
    end
  end
  // first conversion after power on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_ff <= 1'b1;
    end else if (!on_ff) begin
      first_ff <= 1'b1;
    end else if (finish) begin
      first_ff <= 1'b0;
    end
  end
  // successive approximation register, msb first
  logic trial_now;
  logic [4:0] bit_start;
  // auto conversions hold one tick later, so their trials start one tick later
  assign bit_start = (len_ff == SACS_LEN_FIRST) ? SACS_FIRST_BIT :
                     (sh_ff == SACS_SH_AUTO) ? SACS_SH_AUTO + 5'h01 : SACS_NORM_BIT;
  assign trial_now = (state_ff == SACS_CONV) && adc_tick && (cyc_ff >= bit_start) &&
                     (cyc_ff < bit_start + 5'h0a);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sar_ff <= 10'h000;
      bit_ff <= 4'h9;
    end else if (conv_begin || (finish && free_run)) begin
      sar_ff <= 10'h200;
      bit_ff <= 4'h9;
    end else if (trial_now) begin // see R22
      sar_ff[bit_ff] <= cmp_decision;
      if (bit_ff != 4'h0) begin
        sar_ff[bit_ff - 4'h1] <= 1'b1;
        bit_ff <= bit_ff - 4'h1;
      end
    end
  end
  // front end strobes, registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      front <= '0;
    end else begin
      front.sample <= (state_ff == SACS_CONV) && adc_tick && (cyc_ff == sh_ff);
      front.trial <= trial_now;
      front.code <= sar_ff;
      front.channel <= chan_ff;
      front.reference <= ref_ff;
    end
  end
  // result and access block
  logic rd_lo;
  logic rd_hi;
  assign rd_lo = rd && paddr == SACS_OFF_RES_LO;
  assign rd_hi = rd && paddr == SACS_OFF_RES_HI;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      block_ff <= 1'b0;
    end else if (rd_hi) begin
      block_ff <= 1'b0; // see R4
    end else if (rd_lo) begin
      block_ff <= 1'b1; // see R3
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_ff <= 10'h000;
    end else if (finish && !block_ff) begin // see R3, R17
      // the last trial may fall on the finish tick; otherwise the register is final
      result_ff <= trial_now ? {sar_ff[9:1], cmp_decision} : sar_ff;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left_ff <= 1'b0;
    end else begin
      left_ff <= insel_ff[SACS_IS_LEFT];
    end
  end
  // done flag: set wins over write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_ff <= 1'b0;
    end else if (finish) begin
      done_ff <= 1'b1; // see R5, R17
    end else if (wr && paddr == SACS_OFF_CTRL_A && pwdata[SACS_CA_DONE]) begin
      done_ff <= 1'b0;
    end
  end
  // start bit: high for any conversion in progress
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_ff <= 1'b0;
    end else begin
      start_ff <= (nxt_state != SACS_IDLE); // see R6, R12, R17, R19
    end
  end
  // read data mux, bytes built combinationally from the result register
  logic [7:0] lo_byte;
  logic [7:0] hi_byte;
  always_comb begin
    if (left_ff) begin // see R2
      hi_byte = result_ff[9:2];
      lo_byte = {result_ff[1:0], 6'h00};
    end else begin
      hi_byte = {6'h00, result_ff[9:8]};
      lo_byte = result_ff[7:0];
    end
  end
  always_comb begin
    prdata = 32'h0000_0000;
    case (paddr)
      SACS_OFF_CTRL_A: prdata[7:0] = {on_ff, start_ff, auto_ff, done_ff, 1'b0, div_ff};
      SACS_OFF_CTRL_B: prdata[7:0] = {5'h00, tsel_ff};
      SACS_OFF_INSEL: prdata[7:0] = insel_ff;
      SACS_OFF_RES_LO: prdata[7:0] = lo_byte;
      SACS_OFF_RES_HI: prdata[7:0] = hi_byte;
      default: prdata = 32'h0000_0000;
    endcase
  end
  // checks
  property p_block_discard;
    @(posedge pclk) disable iff (!presetn)
    (finish && block_ff) |=> $stable(result_ff);
  endproperty
  a_block_discard: assert property (p_block_discard) else $error("blocked result changed"); // see R3
  property p_done_on_finish;
    @(posedge pclk) disable iff (!presetn)
    finish |=> done_ff;
  endproperty
  a_done_on_finish: assert property (p_done_on_finish) else $error("done flag not set"); // see R5
  property p_release;
    @(posedge pclk) disable iff (!presetn)
    rd_hi |=> !block_ff;
  endproperty
  a_release: assert property (p_release) else $error("block not released"); // see R4
  property p_start_busy;
    @(posedge pclk) disable iff (!presetn)
    (state_ff == SACS_CONV) |-> ##1 start_ff || !on_ff || (finish && !free_run) || $past(finish);
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("start bit low in conversion"); // see R6
  property p_pre_off;
    @(posedge pclk) disable iff (!presetn)
    !on_ff |=> pre_ff == 8'h00;
  endproperty
  a_pre_off: assert property (p_pre_off) else $error("prescaler ran while off"); // see R13
  property p_wait_tick;
    @(posedge pclk) disable iff (!presetn)
    (state_ff == SACS_WAIT && adc_tick) |=> state_ff == SACS_CONV;
  endproperty
  a_wait_tick: assert property (p_wait_tick) else $error("start not on adc edge"); // see R14
  property p_len;
    @(posedge pclk) disable iff (!presetn)
    finish |-> (len_ff == SACS_LEN_NORMAL || len_ff == SACS_LEN_FIRST);
  endproperty
  a_len: assert property (p_len) else $error("bad conversion length"); // see R15
  property p_lock;
    @(posedge pclk) disable iff (!presetn)
    locked && $past(locked) |-> $stable(chan_ff);
  endproperty
  a_lock: assert property (p_lock) else $error("channel moved during conversion"); // see R20
  property p_busy_edge;
    @(posedge pclk) disable iff (!presetn)
    (state_ff != SACS_IDLE && trig_edge && on_ff && !adc_tick) |=> pre_ff == $past(pre_ff) + 8'h01;
  endproperty
  a_busy_edge: assert property (p_busy_edge) else $error("trigger taken while busy"); // see R9
  property p_start_set;
    @(posedge pclk) disable iff (!presetn)
    conv_begin |=> start_ff;
  endproperty
  a_start_set: assert property (p_start_set) else $error("start bit low after start"); // see R12
  c_finish: cover property (@(posedge pclk) disable iff (!presetn) finish);
  c_blocked: cover property (@(posedge pclk) disable iff (!presetn) finish && block_ff);
  c_trig: cover property (@(posedge pclk) disable iff (!presetn) trig_start);
  c_free: cover property (@(posedge pclk) disable iff (!presetn) finish && free_run);
endmodule
`default_nettype wire

//--- rtl/sacs_pkg.sv
package sacs_pkg;
  // register byte offsets
  localparam logic [11:0] SACS_OFF_CTRL_A = 12'h000; // converter_control_a
  localparam logic [11:0] SACS_OFF_CTRL_B = 12'h004; // converter_control_b
  localparam logic [11:0] SACS_OFF_INSEL = 12'h008; // input_select_register
  localparam logic [11:0] SACS_OFF_RES_LO = 12'h00c; // result_low_byte
  localparam logic [11:0] SACS_OFF_RES_HI = 12'h010; // result_high_byte
  // control a field positions
  localparam int SACS_CA_DIV = 0; // clock_divider_select, 3 bits
  localparam int SACS_CA_DONE = 4; // conversion_done_flag
  localparam int SACS_CA_AUTO = 5; // auto_trigger_on
  localparam int SACS_CA_START = 6; // start_conversion_bit
  localparam int SACS_CA_ON = 7; // converter_on
  // input select field positions
  localparam int SACS_IS_CHAN = 0; // channel_select, 5 bits
  localparam int SACS_IS_LEFT = 5; // left_align_result
  localparam int SACS_IS_REF = 6; // reference_select, 2 bits
  // reset values
  localparam logic [7:0] SACS_RST_BYTE = 8'h00;
  // conversion timing in adc clock cycles
  localparam logic [4:0] SACS_LEN_NORMAL = 5'h0d; // 13 cycles
  localparam logic [4:0] SACS_LEN_FIRST = 5'h19; // 25 cycles
  localparam logic [4:0] SACS_SH_NORMAL = 5'h01; // hold after 1.5 cycles
  localparam logic [4:0] SACS_SH_FIRST = 5'h0d; // hold after 13.5 cycles
  localparam logic [4:0] SACS_SH_AUTO = 5'h02; // hold after 2 cycles
  localparam logic [4:0] SACS_FIRST_BIT = 5'h0e; // first bit trial in first conv
  localparam logic [4:0] SACS_NORM_BIT = 5'h02; // first bit trial in normal conv
  localparam int SACS_TRIG_SYNC = 3; // cpu cycles of trigger synchronisation
  localparam logic [4:0] SACS_TRIG_SRC_DONE = 5'h00; // source index of the done flag
  typedef enum logic [1:0] {
    SACS_IDLE = 2'b00,
    SACS_WAIT = 2'b01,
    SACS_CONV = 2'b10
  } sacs_state_type;
  typedef struct packed {
    logic sample; // sample-and-hold strobe
    logic trial; // bit trial strobe
    logic [9:0] code; // trial code to the dac
    logic [4:0] channel; // latched channel
    logic [1:0] reference; // latched reference
  } sacs_front_type;
endpackage

//--- sim/sacs_front_model.sv
`timescale 1ns/1ns
`default_nettype none
// analog front end: eight input levels, a hold stage and a comparator
module sacs_front_model
  import sacs_pkg::*;
(
  input wire logic pclk, // cpu clock
  input wire logic presetn, // reset, active low
  input wire sacs_front_type front, // strobes from the sequencer
  input wire logic [79:0] levels, // eight 10-bit input levels
  output logic cmp_decision // held input at or above trial code
);
  logic [9:0] held_ff; // held input sample
  // capture the latched channel on the sample strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      held_ff <= 10'h000;
    end else if (front.sample) begin
      held_ff <= levels[int'(front.channel[2:0]) * 10 +: 10];
    end
  end
  // one decision per trial code, so the result equals the held level
  assign cmp_decision = (held_ff >= front.code);
endmodule
`default_nettype wire

//--- sim/sar_adc_conversion_sequencer_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
// self-checking bench for the conversion sequencer
module sar_adc_conversion_sequencer_tb_top import sacs_pkg::*;;
  logic pclk, presetn, psel, penable, pwrite; // clock, reset, apb controls
  logic [11:0] paddr; // apb address
  logic [31:0] pwdata, prdata, rd; // apb data, last read
  logic pready, pslverr, err; // apb answer, last error
  logic [7:0] trig_sources; // trigger levels
  logic cmp_decision; // comparator result
  sacs_front_type front; // front end strobes
  logic [79:0] levels; // input levels per channel
  logic [9:0] v; // saved level
  int n_fail = 0, samples_checked = 0, cyc = 0, n_samp = 0, n_trial = 0; // counters
  integer seed; // random seed
  int d, b, bt, t_acc; // duration, base counts, access cycle
  sacs_sequencer sacs_sequencer_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trig_sources(trig_sources), .cmp_decision(cmp_decision), .front(front));
  sacs_front_model sacs_front_model_inst (.pclk(pclk), .presetn(presetn),
    .front(front), .levels(levels), .cmp_decision(cmp_decision));
  // 100 mhz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // cycle count and sample strobe count
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (front.sample === 1'b1) begin
      n_samp <= n_samp + 1;
    end
    if (front.trial === 1'b1) begin
      n_trial <= n_trial + 1;
    end
  end
  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one apb transfer, answer taken at the pready edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] dat);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= dat;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) n_fail++; // no answer counts as a mismatch
    rd = prdata;
    err = pslverr;
    t_acc = cyc;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // expected level of a channel
  function automatic logic [9:0] lv(input int ch);
    return levels[ch * 10 +: 10];
  endfunction
  // duration within the window of a count
  function automatic logic [31:0] in_rng(input int dur, input int lo);
    return {31'h0, dur >= lo && dur <= lo + 8};
  endfunction
  // single conversion, optional selection write while busy
  task automatic convert(input logic [31:0] mid, output int dur);
    int k;
    int t0;
    apb(1'b1, SACS_OFF_CTRL_A, 32'h000000d0); // on, start, clear done
    t0 = t_acc;
    if (mid[31]) begin
      @(posedge pclk);
      apb(1'b1, SACS_OFF_INSEL, {24'h0, mid[7:0]});
    end
    k = 0;
    do begin
      apb(1'b0, SACS_OFF_CTRL_A, 32'h0);
      k++;
    end while (rd[SACS_CA_START] !== 1'b0 && k < 60);
    if (rd[SACS_CA_START] !== 1'b0) n_fail++; // conversion never ended
    dur = t_acc - t0;
  endtask
  // read low then high byte and compare with the model
  task automatic res(input int ch, input bit l);
    logic [9:0] x;
    x = lv(ch);
    apb(1'b0, SACS_OFF_RES_LO, 32'h0);
    check(rd, l ? {24'h0, x[1:0], 6'h00} : {24'h0, x[7:0]});
    apb(1'b0, SACS_OFF_RES_HI, 32'h0);
    check(rd, l ? {24'h0, x[9:2]} : {30'h0, x[9:8]});
  endtask
  // verdict and end of run
  task automatic close_out;
    $display("counts: checked=%0d failed=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // hang guard, far beyond the expected run
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    close_out();
  end
  // main sequence
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    trig_sources = 8'h00;
    presetn = 1'b0;
    seed = 32'h46d8a340;
    for (int i = 0; i < 8; i++) levels[i * 10 +: 10] = 10'($random(seed));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    // reset values, unmapped place, start while off
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, 12'(i * 4), 32'h0);
      check(rd, 32'h0);
    end
    apb(1'b0, 12'h014, 32'h0);
    check({31'h0, err}, 32'h1);
    apb(1'b1, SACS_OFF_CTRL_A, 32'h00000040);
    repeat (40) @(posedge pclk);
    apb(1'b0, SACS_OFF_CTRL_A, 32'h0);
    check(rd, 32'h0);
    check(32'(n_samp), 32'h0);
    $display("test reset done");
    // first conversion, right aligned
    apb(1'b1, SACS_OFF_INSEL, 32'h000000c3);
    check({30'h0, front.reference}, 32'h0);
    b = n_samp;
    bt = n_trial;
    convert(32'h0, d);
    check(in_rng(d, 50), 32'h1);
    check(32'(n_samp - b), 32'h1);
    check(32'(n_trial - bt), 32'ha);
    check({30'h0, front.reference}, 32'h3);
    check({31'h0, rd[SACS_CA_DONE]}, 32'h1);
    res(3, 1'b0);
    $display("test first conversion done");
    // normal conversion, left aligned
    apb(1'b1, SACS_OFF_INSEL, 32'h25);
    convert(32'h0, d);
    check(in_rng(d, 26), 32'h1);
    res(5, 1'b1);
    $display("test normal conversion done");
    // low byte read blocks, high byte read releases
    v = lv(5);
    apb(1'b0, SACS_OFF_RES_LO, 32'h0);
    levels[50 +: 10] <= v ^ 10'h2aa;
    convert(32'h0, d);
    check({31'h0, rd[SACS_CA_DONE]}, 32'h1);
    apb(1'b0, SACS_OFF_RES_HI, 32'h0);
    check(rd, {24'h0, v[9:2]});
    convert(32'h0, d);
    res(5, 1'b1);
    $display("test result lock done");
    // channel change while busy
    apb(1'b1, SACS_OFF_INSEL, 32'h03);
    convert(32'h80000006, d);
    res(3, 1'b0);
    convert(32'h0, d);
    res(6, 1'b0);
    $display("test channel change done");
    // auto trigger on source 1
    apb(1'b1, SACS_OFF_CTRL_B, 32'h01);
    apb(1'b1, SACS_OFF_CTRL_A, 32'h000000b0);
    b = n_samp;
    trig_sources <= 8'h02 | (8'($random(seed)) & 8'hfc);
    repeat (6) @(posedge pclk);
    apb(1'b0, SACS_OFF_CTRL_A, 32'h0);
    check({31'h0, rd[SACS_CA_START]}, 32'h1);
    trig_sources <= 8'h00;
    @(posedge pclk);
    trig_sources <= 8'h02;
    repeat (80) @(posedge pclk);
    check(32'(n_samp - b), 32'h1);
    res(6, 1'b0);
    apb(1'b1, SACS_OFF_CTRL_A, 32'h000000f0);
    repeat (40) @(posedge pclk);
    check(32'(n_samp - b), 32'h2);
    trig_sources <= 8'h00;
    $display("test auto trigger done");
    // free running on the done flag
    apb(1'b1, SACS_OFF_CTRL_B, 32'h00);
    b = n_samp;
    apb(1'b1, SACS_OFF_CTRL_A, 32'h000000f1);
    repeat (240) @(posedge pclk);
    apb(1'b0, SACS_OFF_CTRL_A, 32'h0);
    check({31'h0, rd[SACS_CA_START]}, 32'h1);
    check({31'h0, n_samp - b >= 4}, 32'h1);
    res(6, 1'b0);
    apb(1'b1, SACS_OFF_CTRL_A, 32'h0);
    $display("test free running done");
    close_out();
  end
endmodule
`default_nettype wire
